//--- core/pdm_pkg.sv
// package for the port d pin function mux: register map, fields, resets
// assumes a 32-bit ahb-lite bus; printed offsets are word indices
package pdm_pkg;

  // register word indices; byte address is four times the index
  localparam logic [13:0] IDX_PULL_DOWN    = 14'h0464;
  localparam logic [13:0] IDX_STRAP_PD     = 14'h046E;
  localparam logic [13:0] IDX_FUNC_SELECT  = 14'h0C0E;
  localparam logic [13:0] IDX_PIN_DATA     = 14'h0C10;
  localparam logic [13:0] IDX_STRAP_STATUS = 14'h0C11;

  // pin count and strap count
  localparam int PIN_COUNT   = 3;
  localparam int STRAP_COUNT = 9;

  // function field: two bits per pin, pin n at bits 2n+1..2n
  localparam int FUNC_WIDTH = 2;
  localparam logic [1:0] FUNC_GP_IN  = 2'h0;
  localparam logic [1:0] FUNC_GP_OUT = 2'h2;

  // field positions
  localparam int PULL_LSB      = 8;
  localparam int DIN_LSB       = 4;
  localparam int DOUT_LSB      = 0;
  localparam int STRAP_PD_LSB  = 0;

  // writable bits of each register
  localparam logic [15:0] FUNC_WMASK     = 16'h003F;
  localparam logic [15:0] PULL_WMASK     = 16'h0700;
  localparam logic [15:0] STRAP_PD_WMASK = 16'h01FF;
  localparam logic [15:0] DOUT_WMASK     = 16'h0007;

  // reset values
  localparam logic [15:0] FUNC_RST     = 16'h0000;
  localparam logic [15:0] PULL_RST     = 16'h0700;
  localparam logic [15:0] STRAP_PD_RST = 16'h01FF;
  localparam logic [15:0] DOUT_RST     = 16'h0000;

  // ahb-lite address phase carrier
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
  } pdm_ahb_req_t;

endpackage : pdm_pkg

//--- core/pdm_sync.sv
// two flip-flop synchroniser for pin levels
// assumes inputs are asynchronous; no reset, so it tracks pins in reset
`timescale 1ns/1ps
module pdm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // stage_one feeds only the second stage
  always_ff @(posedge clock_in) begin
    stage_one <= async_in;
    sync_out  <= stage_one;
  end

endmodule : pdm_sync

//--- core/pdm_port_d_mux.sv
// port d pin function mux: three pins, pull-downs, config strap latch
// assumes one ahb-lite master, hready loops back from hreadyout
// Functional notes
// - pin 2 function at bits 5-4; 00b input by default, 10b output.
// - pin 1 function at bits 3-2; 00b input by default, 10b output.
// - pin 0 function at bits 1-0; 00b input by default, 10b output.
// - pull-down enables: pin 2 bit 10, pin 1 bit 9, pin 0 bit 8.
// - nine straps sampled at reset and held as configuration afterwards.
// - straps captured only at reset release; later changes are ignored.
// - strap pull-downs on out of reset; software may switch them off.
`timescale 1ns/1ps
module pdm_port_d_mux (
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  input  wire pdm_pkg::pdm_ahb_req_t ahb_req_in,
  input  wire logic [31:0]          hwdata_in,
  input  wire logic                 hready_in,
  output logic                      hreadyout_out,
  output logic                      hresp_out,
  output logic      [31:0]          hrdata_out,
  input  wire logic [2:0]           port_d_pin_in,
  output logic      [2:0]           port_d_pin_out,
  output logic      [2:0]           port_d_pin_oe_n_out,
  output logic      [2:0]           port_d_pulldown_en_out,
  input  wire logic [8:0]           config_strap_inputs_in,
  output logic      [8:0]           config_strap_out,
  output logic      [8:0]           strap_pulldown_en_out
);

  logic [15:0] func_sel;
  logic [15:0] pull_down;
  logic [15:0] strap_pd;
  logic [15:0] pin_dout;
  logic [15:0] next_func_sel;
  logic [15:0] next_pull_down;
  logic [15:0] next_strap_pd;
  logic [15:0] next_pin_dout;
  logic        wr_pend;
  logic [13:0] wr_idx;
  logic        next_wr_pend;
  logic [13:0] next_wr_idx;
  logic [31:0] next_rdata;
  logic [2:0]  next_oe_n;
  logic [2:0]  pin_sync;
  logic [8:0]  strap_sync;
  logic        captured;
  logic [8:0]  next_strap;
  logic        xfer;

  pdm_sync #(
    .WIDTH (pdm_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clock_in (clock_in),
    .async_in (port_d_pin_in),
    .sync_out (pin_sync)
  );

  pdm_sync #(
    .WIDTH (pdm_pkg::STRAP_COUNT)
  ) u_strap_sync (
    .clock_in (clock_in),
    .async_in (config_strap_inputs_in),
    .sync_out (strap_sync)
  );

  assign xfer = ahb_req_in.hsel && ahb_req_in.htrans[1] && hready_in;

  // register file: writes land at the end of the data phase
  always_comb begin
    next_func_sel  = func_sel;
    next_pull_down = pull_down;
    next_strap_pd  = strap_pd;
    next_pin_dout  = pin_dout;
    if (wr_pend) begin
      case (wr_idx)
        pdm_pkg::IDX_FUNC_SELECT: begin
          next_func_sel = hwdata_in[15:0] & pdm_pkg::FUNC_WMASK;
        end
        pdm_pkg::IDX_PULL_DOWN: begin
          next_pull_down = hwdata_in[15:0] & pdm_pkg::PULL_WMASK;
        end
        pdm_pkg::IDX_STRAP_PD: begin
          next_strap_pd = hwdata_in[15:0] & pdm_pkg::STRAP_PD_WMASK;
        end
        pdm_pkg::IDX_PIN_DATA: begin
          next_pin_dout = hwdata_in[15:0] & pdm_pkg::DOUT_WMASK;
        end
        default: begin
          next_pin_dout = pin_dout;
        end
      endcase
    end
  end

  // address phase capture and read mux; reads see a write just ending
  always_comb begin
    next_wr_pend = xfer && ahb_req_in.hwrite;
    next_wr_idx  = ahb_req_in.haddr[15:2];
    next_rdata   = 32'h00000000;
    if (xfer && !ahb_req_in.hwrite) begin
      case (ahb_req_in.haddr[15:2])
        pdm_pkg::IDX_FUNC_SELECT: begin
          next_rdata[15:0] = next_func_sel;
        end
        pdm_pkg::IDX_PULL_DOWN: begin
          next_rdata[15:0] = next_pull_down;
        end
        pdm_pkg::IDX_STRAP_PD: begin
          next_rdata[15:0] = next_strap_pd;
        end
        pdm_pkg::IDX_PIN_DATA: begin
          next_rdata[15:0] = next_pin_dout;
          next_rdata[pdm_pkg::DIN_LSB +: 3] = pin_sync;
        end
        pdm_pkg::IDX_STRAP_STATUS: begin
          next_rdata[8:0] = config_strap_out;
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // driver enable per pin; reserved codes leave the driver off
  for (genvar i = 0; i < pdm_pkg::PIN_COUNT; i++) begin : g_pin
    assign next_oe_n[i] =
      next_func_sel[i*pdm_pkg::FUNC_WIDTH +: pdm_pkg::FUNC_WIDTH]
      != pdm_pkg::FUNC_GP_OUT;
  end

  // strap latch loads once, at first edge after release
  always_comb begin
    next_strap = captured ? config_strap_out : strap_sync;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      func_sel      <= pdm_pkg::FUNC_RST;
      pull_down     <= pdm_pkg::PULL_RST;
      strap_pd      <= pdm_pkg::STRAP_PD_RST;
      pin_dout      <= pdm_pkg::DOUT_RST;
      wr_pend       <= 1'b0;
      wr_idx        <= 14'h0000;
      hrdata_out    <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      port_d_pin_oe_n_out <= 3'h7;
      captured      <= 1'b0;
      config_strap_out <= 9'h000;
    end else begin
      func_sel      <= next_func_sel;
      pull_down     <= next_pull_down;
      strap_pd      <= next_strap_pd;
      pin_dout      <= next_pin_dout;
      wr_pend       <= next_wr_pend;
      wr_idx        <= next_wr_idx;
      hrdata_out    <= next_rdata;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      port_d_pin_oe_n_out <= next_oe_n;
      captured      <= 1'b1;
      config_strap_out <= next_strap;
    end
  end

  // outputs are copies of register flops
  assign port_d_pin_out =
    pin_dout[pdm_pkg::DOUT_LSB +: pdm_pkg::PIN_COUNT];
  assign port_d_pulldown_en_out =
    pull_down[pdm_pkg::PULL_LSB +: pdm_pkg::PIN_COUNT];
  assign strap_pulldown_en_out =
    strap_pd[pdm_pkg::STRAP_PD_LSB +: pdm_pkg::STRAP_COUNT];

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_func_write;
    xfer && ahb_req_in.hwrite
      && ahb_req_in.haddr[15:2] == pdm_pkg::IDX_FUNC_SELECT
    ##1 1'b1;
  endsequence

  sequence s_pin_read;
    xfer && !ahb_req_in.hwrite
      && ahb_req_in.haddr[15:2] == pdm_pkg::IDX_PIN_DATA;
  endsequence

  sequence s_strap_read;
    xfer && !ahb_req_in.hwrite
      && ahb_req_in.haddr[15:2] == pdm_pkg::IDX_STRAP_STATUS;
  endsequence

  a_pin2_func_out: assert property (
    s_func_write |=> port_d_pin_oe_n_out[2] == ($past(hwdata_in[5:4]) != 2'h2)
  ) else $error("pin 2 driver does not follow function write");

  a_pin1_func_out: assert property (
    s_func_write |=> port_d_pin_oe_n_out[1] == ($past(hwdata_in[3:2]) != 2'h2)
  ) else $error("pin 1 driver does not follow function write");

  a_pin0_func_out: assert property (
    s_func_write |=> port_d_pin_oe_n_out[0] == ($past(hwdata_in[1:0]) != 2'h2)
  ) else $error("pin 0 driver does not follow function write");

  a_pull_down_map: assert property (
    wr_pend && wr_idx == pdm_pkg::IDX_PULL_DOWN
    |=> port_d_pulldown_en_out == $past(hwdata_in[10:8])
  ) else $error("pin pull-down enables do not match written bits");

  a_strap_sample_once: assert property (
    !rst_in && !captured
    |=> config_strap_out == $past(strap_sync) && captured
  ) else $error("straps not captured at reset release");

  a_strap_hold_value: assert property (
    captured |=> $stable(config_strap_out)
  ) else $error("strap configuration changed after capture");

  a_strap_pd_default: assert property (
    !captured |-> strap_pulldown_en_out == 9'h1FF
  ) else $error("strap pull-downs not enabled out of reset");

  a_input_level_read: assert property (
    s_pin_read |=> hrdata_out[6:4] == $past(pin_sync)
  ) else $error("read of pin level does not show sampled pins");

  a_input_driver_off: assert property (
    func_sel[5:4] != 2'h2 && func_sel[3:2] != 2'h2 && func_sel[1:0] != 2'h2
    |-> port_d_pin_oe_n_out == 3'h7
  ) else $error("driver enabled while all pins select input");

  a_pin2_reset_in: assert property (
    !captured |-> func_sel[5:4] == pdm_pkg::FUNC_GP_IN
  ) else $error("pin 2 function not input out of reset");

  a_pin1_reset_in: assert property (
    !captured |-> func_sel[3:2] == pdm_pkg::FUNC_GP_IN
  ) else $error("pin 1 function not input out of reset");

  a_pin0_reset_in: assert property (
    !captured |-> func_sel[1:0] == pdm_pkg::FUNC_GP_IN
  ) else $error("pin 0 function not input out of reset");

  a_pin2_out_drive: assert property (
    func_sel[5:4] == pdm_pkg::FUNC_GP_OUT |-> !port_d_pin_oe_n_out[2]
  ) else $error("pin 2 driver off while output selected");

  a_pin1_out_drive: assert property (
    func_sel[3:2] == pdm_pkg::FUNC_GP_OUT |-> !port_d_pin_oe_n_out[1]
  ) else $error("pin 1 driver off while output selected");

  a_pin0_out_drive: assert property (
    func_sel[1:0] == pdm_pkg::FUNC_GP_OUT |-> !port_d_pin_oe_n_out[0]
  ) else $error("pin 0 driver off while output selected");

  for (genvar k = 0; k < pdm_pkg::PIN_COUNT; k++) begin : g_pin_chk
    a_input_pin_off: assert property (
      @(posedge clock_in) disable iff (rst_in)
      func_sel[k*pdm_pkg::FUNC_WIDTH +: pdm_pkg::FUNC_WIDTH]
        != pdm_pkg::FUNC_GP_OUT
      |-> port_d_pin_oe_n_out[k]
    ) else $error("driver enabled on a pin not set to output");
  end

  a_pull_down_reset: assert property (
    !captured |-> port_d_pulldown_en_out
      == pdm_pkg::PULL_RST[pdm_pkg::PULL_LSB +: pdm_pkg::PIN_COUNT]
  ) else $error("pin pull-downs not enabled out of reset");

  a_strap_pd_write: assert property (
    wr_pend && wr_idx == pdm_pkg::IDX_STRAP_PD
    |=> strap_pulldown_en_out == $past(hwdata_in[8:0])
  ) else $error("strap pull-downs do not match written bits");

  a_strap_status_read: assert property (
    s_strap_read |=> hrdata_out[8:0] == $past(config_strap_out)
      && hrdata_out[31:9] == 23'h000000
  ) else $error("strap status read does not show latched straps");

  a_bus_okay_ready: assert property (
    hreadyout_out && !hresp_out
  ) else $error("bus slave stalled or answered with an error");

  a_rdata_idle_zero: assert property (
    !(xfer && !ahb_req_in.hwrite) |=> hrdata_out == 32'h00000000
  ) else $error("read data not zero outside a read data phase");

  a_pin_data_write: assert property (
    wr_pend && wr_idx == pdm_pkg::IDX_PIN_DATA
    |=> port_d_pin_out == $past(hwdata_in[2:0])
  ) else $error("pin output levels do not match written bits");

endmodule : pdm_port_d_mux

//--- tb/tb_port_d_pin_function_mux.sv
// self-checking bench for the port d pin function mux
// assumes one ahb-lite master here, hready looped back from hreadyout
`timescale 1ns/1ps
module tb_port_d_pin_function_mux;
  logic                  clock_in = 1'b0;
  logic                  rst_in;
  pdm_pkg::pdm_ahb_req_t req;
  logic [31:0]           hwdata;
  logic [2:0]            pin_in;
  logic [8:0]            straps;
  wire logic             hreadyout;
  wire logic             hresp;
  wire logic [31:0]      hrdata;
  wire logic [2:0]       pin_out;
  wire logic [2:0]       oe_n;
  wire logic [2:0]       pd_en;
  wire logic [8:0]       strap_cfg;
  wire logic [8:0]       strap_pd;
  logic [31:0]           rd;
  int                    err_total = 0;
  int                    n_tests = 0;

  always #2 clock_in = ~clock_in;

  pdm_port_d_mux pdm_port_d_mux_inst (
    .clock_in(clock_in), .rst_in(rst_in), .ahb_req_in(req),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .hrdata_out(hrdata), .port_d_pin_in(pin_in),
    .port_d_pin_out(pin_out), .port_d_pin_oe_n_out(oe_n),
    .port_d_pulldown_en_out(pd_en), .config_strap_inputs_in(straps),
    .config_strap_out(strap_cfg), .strap_pulldown_en_out(strap_pd));

  task automatic finish_test();
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  // waits for hready at rising edges, bounded so a stuck bus ends the run
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge clock_in);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      err_total++;
      finish_test();
    end
  endtask : wait_ready

  // one single word transfer; byte address is four times the index
  task automatic xfer(input logic wr, input logic [13:0] idx,
                      input logic [31:0] wd);
    @(posedge clock_in);
    req.hsel   <= 1'b1;
    req.haddr  <= {16'h0000, idx, 2'h0};
    req.htrans <= 2'h2;
    req.hwrite <= wr;
    req.hsize  <= 3'h2;
    wait_ready();
    req.hsel   <= 1'b0;
    req.htrans <= 2'h0;
    hwdata     <= wd;
    wait_ready();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
    #1;
  endtask : xfer

  task automatic reset_dut(input logic [8:0] s);
    @(posedge clock_in);
    rst_in <= 1'b1;
    straps <= s;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    #1;
  endtask : reset_dut

  initial begin
    rst_in = 1'b1;
    req    = '0;
    hwdata = 32'h0;
    pin_in = 3'h0;
    straps = 9'h1A5;
    reset_dut(9'h1A5);
    chk(strap_cfg, 32'h1A5);
    chk(oe_n, 32'h7);
    chk(pd_en, 32'h7);
    chk(strap_pd, 32'h1FF);
    xfer(1'b0, pdm_pkg::IDX_FUNC_SELECT, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, pdm_pkg::IDX_PULL_DOWN, 32'h0);
    chk(rd, 32'h700);
    // only codes 00b and 10b written
    // each pin to output alone, then read back while still output
    for (int n = 0; n < 3; n++) begin
      xfer(1'b1, pdm_pkg::IDX_FUNC_SELECT, 32'h2 << (2 * n));
      chk(oe_n, ~(32'h1 << n) & 32'h7);
      xfer(1'b0, pdm_pkg::IDX_FUNC_SELECT, 32'h0);
      chk(rd, 32'h2 << (2 * n));
      xfer(1'b1, pdm_pkg::IDX_PULL_DOWN, 32'h100 << n);
      chk(pd_en, 32'h1 << n);
    end
    xfer(1'b1, pdm_pkg::IDX_FUNC_SELECT, 32'h0);
    chk(oe_n, 32'h7);
    xfer(1'b1, pdm_pkg::IDX_PIN_DATA, 32'h5);
    chk(pin_out, 32'h5);
    @(posedge clock_in);
    pin_in <= 3'h6;
    repeat (3) @(posedge clock_in);
    xfer(1'b0, pdm_pkg::IDX_PIN_DATA, 32'h0);
    chk(rd, 32'h65);
    xfer(1'b1, pdm_pkg::IDX_FUNC_SELECT, 32'h2A);
    chk(oe_n, 32'h0);
    chk(pin_out, 32'h5);
    xfer(1'b1, pdm_pkg::IDX_STRAP_PD, 32'h0);
    chk(strap_pd, 32'h0);
    // strap pins move after capture; latched copy must hold
    @(posedge clock_in);
    straps <= 9'h05A;
    repeat (5) @(posedge clock_in);
    #1;
    chk(strap_cfg, 32'h1A5);
    xfer(1'b0, pdm_pkg::IDX_STRAP_STATUS, 32'h0);
    chk(rd, 32'h1A5);
    xfer(1'b1, 14'h0123, 32'h0000FFFF);
    xfer(1'b0, pdm_pkg::IDX_FUNC_SELECT, 32'h0);
    chk(rd, 32'h2A);
    xfer(1'b0, 14'h0123, 32'h0);
    chk(rd, 32'h0);
    // second reset in mid-run recaptures and restores defaults
    reset_dut(9'h0C3);
    chk(strap_cfg, 32'h0C3);
    chk(oe_n, 32'h7);
    chk(strap_pd, 32'h1FF);
    chk(pd_en, 32'h7);
    chk(pin_out, 32'h0);
    xfer(1'b0, pdm_pkg::IDX_FUNC_SELECT, 32'h0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : tb_port_d_pin_function_mux
